// ### pkg/vrts_consts.svh
`ifndef VRTS_CONSTS_SVH
`define VRTS_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define VRTS_ADDR_CONTROL 12'h000
`define VRTS_ADDR_STATUS 12'h004

// ----------------------------------------
// control register fields
// ----------------------------------------
`define VRTS_BIT_REF_EN 7
`define VRTS_BIT_READY 6
`define VRTS_BIT_TEMP_EN 5
`define VRTS_BIT_TEMP_RANGE 4
`define VRTS_GAIN_HI 1
`define VRTS_GAIN_LO 0
`define VRTS_WRITE_MASK 8'hb3
`define VRTS_CONTROL_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define VRTS_CLK_MHZ 100
`define VRTS_SETTLE_NS 1000
`define VRTS_SETTLE_CYCLES ((`VRTS_SETTLE_NS * `VRTS_CLK_MHZ + 999) / 1000)
`define VRTS_TEMP_ACQ_US 200
`define VRTS_TEMP_ACQ_CYCLES (`VRTS_TEMP_ACQ_US * `VRTS_CLK_MHZ)

`endif

// ### pkg/vrts_pkg.sv
package vrts_pkg;
  typedef enum logic [1:0] {VRTS_GAIN_OFF, VRTS_GAIN_X1, VRTS_GAIN_X2, VRTS_GAIN_RSVD} vrts_gain_t;
  typedef enum logic [1:0] {VRTS_REF_OFF, VRTS_REF_SETTLING, VRTS_REF_READY} vrts_ref_state_t;
endpackage

// ### verilog/vrts_ctrl.sv
// How it works
// (R1) reference runs while control bit 7 is one, off otherwise.
// (R2) bit 6 is a read-only ready flag, one when reference is usable.
// (R3) after enable, ready stays clear until the settle time elapses, then sets.
// (R4) temperature circuit runs while control bit 5 is one.
// (R5) bit 4 selects temperature high range when one, low range when zero.
// (R6) bits 1:0 pick converter reference gain: off, 1x, 2x, reserved.
// (R7) bits 3 and 2 read zero and ignore writes.
// (R8) all writable bits clear on any reset.
// (R9) temperature output goes to its own dedicated converter channel.
// (R10) software waits the acquisition delay before and between temperature conversions.
// (R11) ready clears at once when the reference enable is written zero.
`include "vrts_consts.svh"

module vrts_ctrl
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog side
  output logic reference_enable,
  output logic reference_ready,
  output logic temp_sense_enable,
  output logic temp_range_select,
  output logic [1:0] converter_ref_gain,
  output logic gain_x1,
  output logic gain_x2,
  output logic temp_channel_connect
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic access;
  logic wr_ctrl;
  logic hit;
  logic [7:0] control;
  vrts_pkg::vrts_ref_state_t ref_state;
  logic [7:0] settle_cnt;
  logic [31:0] next_prdata;

  assign access = psel && !penable;
  assign hit = (paddr == `VRTS_ADDR_CONTROL) || (paddr == `VRTS_ADDR_STATUS);
  assign wr_ctrl = access && pwrite && (paddr == `VRTS_ADDR_CONTROL);

  // pready rises one cycle after setup, answer in the access phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (clk_en)
    begin
      pready <= access;
      pslverr <= access && !hit;
      prdata <= next_prdata;
    end
  end

  always_comb
  begin
    next_prdata = 32'h0;
    if (access && !pwrite && hit)
    begin
      next_prdata[7:0] = control & `VRTS_WRITE_MASK; // see (R7)
      next_prdata[`VRTS_BIT_READY] = (ref_state == vrts_pkg::VRTS_REF_READY); // see (R2)
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      control <= `VRTS_CONTROL_RESET; // see (R8)
    else if (clk_en && wr_ctrl)
      control <= pwdata[7:0] & `VRTS_WRITE_MASK; // see (R7)
  end

  // ----------------------------------------
  // reference settle tracking
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_state <= vrts_pkg::VRTS_REF_OFF;
      settle_cnt <= 8'h00;
    end
    else if (clk_en)
    begin
      if (!control[`VRTS_BIT_REF_EN] || (wr_ctrl && !pwdata[`VRTS_BIT_REF_EN]))
      begin
        ref_state <= vrts_pkg::VRTS_REF_OFF; // see (R11)
        settle_cnt <= 8'h00;
      end
      else
      begin
        unique case (ref_state)
          vrts_pkg::VRTS_REF_OFF:
          begin
            ref_state <= vrts_pkg::VRTS_REF_SETTLING;
            settle_cnt <= 8'h00;
          end
          vrts_pkg::VRTS_REF_SETTLING:
          begin
            if (settle_cnt == 8'(`VRTS_SETTLE_CYCLES - 1))
              ref_state <= vrts_pkg::VRTS_REF_READY; // see (R3)
            else
              settle_cnt <= settle_cnt + 8'h01;
          end
          vrts_pkg::VRTS_REF_READY:
            ref_state <= vrts_pkg::VRTS_REF_READY;
          default:
            ref_state <= vrts_pkg::VRTS_REF_OFF;
        endcase
      end
    end
  end

  // ----------------------------------------
  // analog controls
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reference_enable <= 1'b0;
      reference_ready <= 1'b0;
      temp_sense_enable <= 1'b0;
      temp_range_select <= 1'b0;
      converter_ref_gain <= 2'h0;
      gain_x1 <= 1'b0;
      gain_x2 <= 1'b0;
      temp_channel_connect <= 1'b0;
    end
    else if (clk_en)
    begin
      reference_enable <= control[`VRTS_BIT_REF_EN]; // see (R1)
      reference_ready <= (ref_state == vrts_pkg::VRTS_REF_READY) && control[`VRTS_BIT_REF_EN]; // see (R2)
      temp_sense_enable <= control[`VRTS_BIT_TEMP_EN]; // see (R4)
      temp_range_select <= control[`VRTS_BIT_TEMP_RANGE]; // see (R5)
      converter_ref_gain <= control[`VRTS_GAIN_HI:`VRTS_GAIN_LO]; // see (R6)
      gain_x1 <= control[`VRTS_GAIN_HI:`VRTS_GAIN_LO] == 2'(vrts_pkg::VRTS_GAIN_X1); // see (R6)
      gain_x2 <= control[`VRTS_GAIN_HI:`VRTS_GAIN_LO] == 2'(vrts_pkg::VRTS_GAIN_X2); // see (R6)
      temp_channel_connect <= control[`VRTS_BIT_TEMP_EN]; // see (R9)
    end
  end

  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  // enabled cycles the reference has been held on, saturating
  logic [7:0] on_cnt;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      on_cnt <= 8'h00;
    else if (clk_en)
    begin
      if (!control[`VRTS_BIT_REF_EN] || (wr_ctrl && !pwdata[`VRTS_BIT_REF_EN]))
        on_cnt <= 8'h00;
      else if (on_cnt != 8'hff)
        on_cnt <= on_cnt + 8'h01;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_REF_FOLLOWS: assert property (@(posedge clk) disable iff (!reset_n) // see (R1)
    clk_en |=> reference_enable == $past(control[`VRTS_BIT_REF_EN])) else $error("reference enable mismatch");
  AST_READY_NEEDS_EN: assert property (@(posedge clk) disable iff (!reset_n) // see (R2)
    reference_ready |-> reference_enable) else $error("ready while reference off");
  AST_SETTLE_DELAY: assert property (@(posedge clk) disable iff (!reset_n) // see (R3)
    $rose(control[`VRTS_BIT_REF_EN]) |-> !reference_ready [*8]) else $error("ready too early");
  AST_SETTLE_DONE: assert property (@(posedge clk) disable iff (!reset_n) // see (R3)
    on_cnt >= 8'(`VRTS_SETTLE_CYCLES + 2) |-> reference_ready) else $error("ready never set");
  AST_READY_RISE: assert property (@(posedge clk) disable iff (!reset_n) // see (R3)
    $rose(reference_ready) |-> on_cnt == 8'(`VRTS_SETTLE_CYCLES + 2)) else $error("ready rose at wrong time");
  AST_TEMP_EN: assert property (@(posedge clk) disable iff (!reset_n) // see (R4)
    clk_en |=> temp_sense_enable == $past(control[`VRTS_BIT_TEMP_EN])) else $error("temp enable mismatch");
  AST_RANGE: assert property (@(posedge clk) disable iff (!reset_n) // see (R5)
    clk_en |=> temp_range_select == $past(control[`VRTS_BIT_TEMP_RANGE])) else $error("range mismatch");
  AST_GAIN_ONEHOT: assert property (@(posedge clk) disable iff (!reset_n) // see (R6)
    gain_x1 == (converter_ref_gain == 2'h1) && gain_x2 == (converter_ref_gain == 2'h2)) else $error("gain decode wrong");
  AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!reset_n) // see (R7)
    control[3:2] == 2'h0) else $error("unused bits set");
  AST_READY_DROP: assert property (@(posedge clk) disable iff (!reset_n) // see (R11)
    (clk_en && wr_ctrl && !pwdata[`VRTS_BIT_REF_EN]) |=> ref_state == vrts_pkg::VRTS_REF_OFF)
    else $error("ready not cleared");
  AST_CHANNEL: assert property (@(posedge clk) disable iff (!reset_n) // see (R9)
    temp_channel_connect == temp_sense_enable) else $error("channel routing mismatch");
  AST_READ_UNUSED: assert property (@(posedge clk) disable iff (!reset_n) // see (R7)
    pready |-> prdata[31:8] == 24'h0 && prdata[3:2] == 2'h0) else $error("unused read bits set");
  AST_READ_READY: assert property (@(posedge clk) disable iff (!reset_n) // see (R2)
    pready && !pwrite && !pslverr |-> prdata[6] == reference_ready) else $error("ready flag read mismatch");
  AST_READY_LOW_DIS: assert property (@(posedge clk) disable iff (!reset_n) // see (R11)
    (clk_en && wr_ctrl && !pwdata[`VRTS_BIT_REF_EN]) ##1 clk_en |=> !reference_ready)
    else $error("ready output not dropped");

  COV_READY: cover property (@(posedge clk) disable iff (!reset_n) $rose(reference_ready));
  COV_TEMP_HIGH: cover property (@(posedge clk) disable iff (!reset_n) temp_sense_enable && temp_range_select);
  COV_GAIN_X2: cover property (@(posedge clk) disable iff (!reset_n) gain_x2);
  COV_BAD_ADDR: cover property (@(posedge clk) disable iff (!reset_n) pslverr && pready);
  COV_FROZEN: cover property (@(posedge clk) disable iff (!reset_n) !clk_en && ref_state == vrts_pkg::VRTS_REF_SETTLING);

endmodule

// ### tb/vrts_analog_model.sv
// ----------------------------------------
// analog reference, temperature circuit and converter mux
// ----------------------------------------
module vrts_analog_model
(
  // control from block
  input wire logic reference_ready,
  input wire logic gain_x1,
  input wire logic gain_x2,
  input wire logic temp_sense_enable,
  input wire logic temp_channel_connect,
  // analog levels seen by converter
  output logic [31:0] ref_mv,
  output logic temp_on_channel
);
  timeunit 1ns;
  timeprecision 1ns;
  // reference only usable once settled
  assign ref_mv = !reference_ready ? 32'd0 : gain_x2 ? 32'd2048 : gain_x1 ? 32'd1024 : 32'd0;
  assign temp_on_channel = temp_sense_enable & temp_channel_connect;
endmodule

// ### tb/tb.sv
`include "vrts_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic reference_enable, reference_ready, temp_sense_enable, temp_range_select;
  logic gain_x1, gain_x2, temp_channel_connect, temp_on_channel;
  logic [1:0] converter_ref_gain;
  logic [7:0] outs;
  logic [31:0] ref_mv;
  int n_errors, check_count, cyc, n;
  int mv_tab[4] = '{0, 1024, 2048, 0};
  assign outs = {reference_enable, reference_ready, temp_sense_enable, temp_range_select,
                 gain_x1, gain_x2, converter_ref_gain};
  vrts_ctrl dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reference_enable(reference_enable), .reference_ready(reference_ready),
    .temp_sense_enable(temp_sense_enable), .temp_range_select(temp_range_select),
    .converter_ref_gain(converter_ref_gain), .gain_x1(gain_x1), .gain_x2(gain_x2),
    .temp_channel_connect(temp_channel_connect));
  vrts_analog_model model (.reference_ready(reference_ready), .gain_x1(gain_x1), .gain_x2(gain_x2),
    .temp_sense_enable(temp_sense_enable), .temp_channel_connect(temp_channel_connect),
    .ref_mv(ref_mv), .temp_on_channel(temp_on_channel));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(outs, 8'h00);
    chk(temp_on_channel, 1'b0);
    apb(`VRTS_ADDR_CONTROL, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_write_all;
    apb(`VRTS_ADDR_CONTROL, 1'b1, 32'hffff_ffff);
    chk(outs, 8'hb3);
    chk(temp_on_channel, 1'b1);
    apb(`VRTS_ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'hb3);
    n = 0;
    while (reference_ready !== 1'b1 && n < `VRTS_SETTLE_CYCLES + 10)
    begin
      @(posedge clk);
      n++;
    end
    chk(n >= `VRTS_SETTLE_CYCLES - 6 && reference_ready === 1'b1, 1'b1);
    apb(`VRTS_ADDR_CONTROL, 1'b0, 32'h0);
    chk(rd, 32'hf3);
    $display("settle test done");
  endtask
  task automatic t_gain;
    for (int g = 0; g < 4; g++)
    begin
      apb(`VRTS_ADDR_CONTROL, 1'b1, 32'h80 | g);
      chk(outs, {4'hc, g == 1, g == 2, g[1:0]});
      chk(ref_mv, mv_tab[g]);
    end
    apb(`VRTS_ADDR_CONTROL, 1'b1, 32'h0);
    @(posedge clk);
    #1;
    chk(outs, 8'h00);
    $display("gain test done");
  endtask
  task automatic t_unmapped;
    apb(12'h008, 1'b1, 32'hff);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    apb(`VRTS_ADDR_CONTROL, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b0);
    $display("unmapped test done");
  endtask
  task automatic t_temp_acq;
    apb(`VRTS_ADDR_CONTROL, 1'b1, 32'h20);
    chk(outs, 8'h20);
    chk(temp_on_channel, 1'b1);
    repeat (`VRTS_TEMP_ACQ_CYCLES) @(posedge clk);
    #1;
    chk(temp_on_channel, 1'b1);
    apb(`VRTS_ADDR_CONTROL, 1'b1, 32'h0);
    chk(temp_on_channel, 1'b0);
    $display("temperature test done");
  endtask
  task automatic t_freeze;
    apb(`VRTS_ADDR_CONTROL, 1'b1, 32'h80);
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (2 * `VRTS_SETTLE_CYCLES) @(posedge clk);
    #1;
    chk(reference_ready, 1'b0);
    @(posedge clk);
    clk_en <= 1'b1;
    n = 0;
    while (reference_ready !== 1'b1 && n < `VRTS_SETTLE_CYCLES + 10)
    begin
      @(posedge clk);
      n++;
    end
    chk(n >= `VRTS_SETTLE_CYCLES - 6 && reference_ready === 1'b1, 1'b1);
    apb(`VRTS_ADDR_CONTROL, 1'b1, 32'h0);
    @(posedge clk);
    #1;
    chk(outs, 8'h00);
    $display("freeze test done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 25000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_write_all();
    t_gain();
    t_unmapped();
    t_temp_acq();
    t_freeze();
    wrap_up();
  end
endmodule
